/* tmr_defs.svh */
// constants for the dual timer/counter: addresses, fields, resets, timing
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define TMR_SFR_SPACE_BIT 7
`define TMR_ADDR_CTRL 8'h88
`define TMR_ADDR_MODE 8'h89
`define TMR_ADDR_A_LOW 8'h8A
`define TMR_ADDR_B_LOW 8'h8B
`define TMR_ADDR_A_HIGH 8'h8C
`define TMR_ADDR_B_HIGH 8'h8D
`define TMR_BIT_ADDR_LOW 3'h0
`define TMR_UNIMPL_READ 8'hFF

// ----------------------------------------------------------------------
// timer_control_flags bit positions
// ----------------------------------------------------------------------
`define TMR_CTRL_B_OVF 7
`define TMR_CTRL_B_RUN 6
`define TMR_CTRL_A_OVF 5
`define TMR_CTRL_A_RUN 4
`define TMR_CTRL_B_IRQ 3
`define TMR_CTRL_B_TYPE 2
`define TMR_CTRL_A_IRQ 1
`define TMR_CTRL_A_TYPE 0

// ----------------------------------------------------------------------
// timer_mode_select field positions (counter a low nibble, b high)
// ----------------------------------------------------------------------
`define TMR_MODE_B_LSB 4
`define TMR_MODE_GATE 3
`define TMR_MODE_CT 2
`define TMR_MODE_SEL_HI 1
`define TMR_MODE_SEL_LO 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TMR_RST_CTRL 8'h00
`define TMR_RST_MODE 8'h00
`define TMR_RST_COUNT 8'h00
`define TMR_RST_RDATA 8'hFF

// ----------------------------------------------------------------------
// timing: system clock divided by 4 or by 12 in timer operation
// ----------------------------------------------------------------------
`define TMR_DIV_FAST 4'h4
`define TMR_DIV_SLOW 4'hC
`define TMR_PRE13_LOW 5

`endif

/* tmr_pkg.sv */
// types shared by the dual timer/counter modules
package tmr_pkg;

    typedef enum logic [1:0]
    {
        TMR_MODE_PRESCALE,
        TMR_MODE_FULL,
        TMR_MODE_RELOAD,
        TMR_MODE_SPLIT
    } tmr_mode_e;

    typedef struct packed
    {
        logic [7:0] ctrl_reg;
        logic [7:0] mode_reg;
        logic [7:0] a_low_reg;
        logic [7:0] a_high_reg;
        logic [7:0] b_low_reg;
        logic [7:0] b_high_reg;
        logic [7:0] rdata_reg;
    } tmr_state_s;

    typedef struct packed
    {
        logic [2:0] samp_reg;
        logic fall_reg;
    } tmr_sync_s;

    typedef struct packed
    {
        logic [3:0] cnt_reg;
        logic fast_reg;
        logic slow_reg;
    } tmr_pre_s;

endpackage

/* tmr_sync.sv */
// two-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_sync
    import tmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic pin,
    output logic level,
    output logic fall
);

    tmr_sync_s st_reg;
    tmr_sync_s st_next;

    // stage 0 feeds only stage 1; edge logic looks at stages 1 and 2
    always_comb
    begin
        st_next = st_reg;
        st_next.samp_reg = {st_reg.samp_reg[1:0], pin};
        st_next.fall_reg = st_reg.samp_reg[2] & ~st_reg.samp_reg[1];
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{samp_reg: 3'h7, fall_reg: 1'b0};
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.samp_reg[1];
    assign fall = st_reg.fall_reg;

endmodule

/* tmr_prescale.sv */
// divide-by-4 and divide-by-12 count ticks from the system clock
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_prescale
    import tmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    output logic tick_fast,
    output logic tick_slow
);

    tmr_pre_s st_reg;
    tmr_pre_s st_next;
    logic [3:0] last;

    // one counter serves both rates: 4 divides 12
    always_comb
    begin
        last = `TMR_DIV_SLOW - 4'h1;
        st_next = st_reg;
        st_next.cnt_reg = (st_reg.cnt_reg == last) ? 4'h0
                                                   : st_reg.cnt_reg + 4'h1;
        st_next.slow_reg = (st_reg.cnt_reg == last);
        st_next.fast_reg = (st_reg.cnt_reg[1:0] ==
                            2'(`TMR_DIV_FAST - 4'h1));
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{cnt_reg: 4'h0, fast_reg: 1'b0, slow_reg: 1'b0};
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign tick_fast = st_reg.fast_reg;
    assign tick_slow = st_reg.slow_reg;

endmodule

/* tmr_top.sv */
// dual timer/counter with external interrupt detection, register-mapped
// Behaviour
// - registers at 80-FFh, direct addressing only
// - bit access only where address ends 0/8
// - unimplemented locations and bits read as one
// - overflow sets flag; vector or software clears
// - counter advances only while run bit set
// - irq flag: edge cleared on vector, level follows
// - type bit picks falling edge or low level
// - gate bit also requires irq pin high
// - select bit: internal clock or pin falling edges
// - mode 00: 8-bit counter, 5-bit prescaler
// - mode 01: bytes form one full counter
// - mode 10: low byte reloads from high
// - mode 11 on a: split into two counters
// - mode 11 on b: counter b holds
// - sleep request leaves counters running
// - power-down request freezes everything
// - clock select: divide by 4 or 12
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_top
    import tmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_indirect,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic vector_ack_ovf_a,
    input wire logic vector_ack_ovf_b,
    input wire logic vector_ack_irq_a,
    input wire logic vector_ack_irq_b,
    input wire logic counter_a_clock_select,
    input wire logic counter_b_clock_select,
    input wire logic cpu_sleep_request,
    input wire logic power_down_request,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic count_a_pin,
    input wire logic count_b_pin,
    output logic counter_a_overflow_flag,
    output logic counter_b_overflow_flag,
    output logic ext_irq_a_request,
    output logic ext_irq_b_request
);

    // ------------------------------------------------------------------
    // clock gating and shared tick sources
    // ------------------------------------------------------------------
    // sleep request is deliberately unused: counters keep their clock
    logic run_en;
    logic tick_fast;
    logic tick_slow;
    logic [3:0] pin_raw;
    logic [3:0] pin_lvl;
    logic [3:0] pin_fall;

    assign run_en = ce & ~power_down_request;

    tmr_prescale u_pre
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(run_en),
        .tick_fast(tick_fast),
        .tick_slow(tick_slow)
    );

    // ------------------------------------------------------------------
    // pin synchronisers: irq a, irq b, count a, count b
    // ------------------------------------------------------------------
    assign pin_raw = {count_b_pin, count_a_pin, ext_irq_b_pin, ext_irq_a_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            tmr_sync u_sync
            (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .ce(run_en),
                .pin(pin_raw[gi]),
                .level(pin_lvl[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tmr_state_s st_reg;
    tmr_state_s st_next;

    logic acc_ok;
    logic byte_wr;
    logic bit_wr;
    logic any_wr;
    logic [7:0] cur_byte;
    logic [7:0] wr_byte;
    logic [3:0] mode_a_f;
    logic [3:0] mode_b_f;
    tmr_mode_e mode_a;
    tmr_mode_e mode_b;
    logic tick_a;
    logic tick_b;
    logic inc_a;
    logic inc_b;
    logic inc_a_high;
    logic ovf_a;
    logic ovf_b;
    logic [12:0] pre_a;
    logic [12:0] pre_b;
    logic [15:0] full_a;
    logic [15:0] full_b;
    logic [8:0] low_a;
    logic [8:0] low_b;
    logic [8:0] high_a;
    logic [7:0] ctrl;

    // read view of the current registers; anything else reads ones
    function automatic logic [7:0] read_view(input logic [7:0] addr,
                                             input tmr_state_s s);
        logic [7:0] v;
        v = `TMR_UNIMPL_READ;
        unique case (addr)
            `TMR_ADDR_CTRL: v = s.ctrl_reg;
            `TMR_ADDR_MODE: v = s.mode_reg;
            `TMR_ADDR_A_LOW: v = s.a_low_reg;
            `TMR_ADDR_B_LOW: v = s.b_low_reg;
            `TMR_ADDR_A_HIGH: v = s.a_high_reg;
            `TMR_ADDR_B_HIGH: v = s.b_high_reg;
            default: v = `TMR_UNIMPL_READ;
        endcase
        return v;
    endfunction

    always_comb
    begin
        st_next = st_reg;

        // --------------------------------------------------------------
        // register access decode
        // --------------------------------------------------------------
        acc_ok = ~sfr_indirect & sfr_addr[`TMR_SFR_SPACE_BIT];
        byte_wr = acc_ok & sfr_wr;
        bit_wr = acc_ok & sfr_bit_wr &
                 (sfr_addr[2:0] == `TMR_BIT_ADDR_LOW);
        any_wr = byte_wr | bit_wr;
        cur_byte = read_view(sfr_addr, st_reg);
        wr_byte = sfr_wdata;
        if (bit_wr)
        begin
            wr_byte = cur_byte;
            wr_byte[sfr_bit_sel] = sfr_bit_val;
        end

        // --------------------------------------------------------------
        // count enables
        // --------------------------------------------------------------
        mode_a_f = st_reg.mode_reg[3:0];
        mode_b_f = st_reg.mode_reg[7:`TMR_MODE_B_LSB];
        mode_a = tmr_mode_e'(mode_a_f[`TMR_MODE_SEL_HI:`TMR_MODE_SEL_LO]);
        mode_b = tmr_mode_e'(mode_b_f[`TMR_MODE_SEL_HI:`TMR_MODE_SEL_LO]);
        tick_a = counter_a_clock_select ? tick_fast : tick_slow;
        tick_b = counter_b_clock_select ? tick_fast : tick_slow;
        inc_a = st_reg.ctrl_reg[`TMR_CTRL_A_RUN] &
                (~mode_a_f[`TMR_MODE_GATE] | pin_lvl[0]) &
                (mode_a_f[`TMR_MODE_CT] ? pin_fall[2] : tick_a);
        inc_b = st_reg.ctrl_reg[`TMR_CTRL_B_RUN] &
                (~mode_b_f[`TMR_MODE_GATE] | pin_lvl[1]) &
                (mode_b_f[`TMR_MODE_CT] ? pin_fall[3] : tick_b);
        // split high byte: timer only, run by counter b's run bit
        inc_a_high = st_reg.ctrl_reg[`TMR_CTRL_B_RUN] & tick_a;

        // --------------------------------------------------------------
        // counter a
        // --------------------------------------------------------------
        ovf_a = 1'b0;
        ovf_b = 1'b0;
        pre_a = {st_reg.a_high_reg, st_reg.a_low_reg[4:0]} + 13'h0001;
        full_a = {st_reg.a_high_reg, st_reg.a_low_reg} + 16'h0001;
        low_a = {1'b0, st_reg.a_low_reg} + 9'h001;
        high_a = {1'b0, st_reg.a_high_reg} + 9'h001;
        unique case (mode_a)
            TMR_MODE_PRESCALE:
            begin
                if (inc_a)
                begin
                    // upper three low-byte bits are left as they stand
                    st_next.a_low_reg[4:0] = pre_a[4:0];
                    st_next.a_high_reg = pre_a[12:`TMR_PRE13_LOW];
                    ovf_a = &{st_reg.a_high_reg, st_reg.a_low_reg[4:0]};
                end
            end
            TMR_MODE_FULL:
            begin
                if (inc_a)
                begin
                    st_next.a_low_reg = full_a[7:0];
                    st_next.a_high_reg = full_a[15:8];
                    ovf_a = &{st_reg.a_high_reg, st_reg.a_low_reg};
                end
            end
            TMR_MODE_RELOAD:
            begin
                if (inc_a)
                begin
                    ovf_a = low_a[8];
                    st_next.a_low_reg = low_a[8] ? st_reg.a_high_reg
                                                 : low_a[7:0];
                end
            end
            TMR_MODE_SPLIT:
            begin
                if (inc_a)
                begin
                    st_next.a_low_reg = low_a[7:0];
                    ovf_a = low_a[8];
                end
                if (inc_a_high)
                begin
                    st_next.a_high_reg = high_a[7:0];
                    ovf_b = high_a[8];
                end
            end
        endcase

        // --------------------------------------------------------------
        // counter b; its own overflow is not flagged while a is split
        // --------------------------------------------------------------
        pre_b = {st_reg.b_high_reg, st_reg.b_low_reg[4:0]} + 13'h0001;
        full_b = {st_reg.b_high_reg, st_reg.b_low_reg} + 16'h0001;
        low_b = {1'b0, st_reg.b_low_reg} + 9'h001;
        unique case (mode_b)
            TMR_MODE_PRESCALE:
            begin
                if (inc_b)
                begin
                    st_next.b_low_reg[4:0] = pre_b[4:0];
                    st_next.b_high_reg = pre_b[12:`TMR_PRE13_LOW];
                    if (mode_a != TMR_MODE_SPLIT)
                    begin
                        ovf_b = &{st_reg.b_high_reg, st_reg.b_low_reg[4:0]};
                    end
                end
            end
            TMR_MODE_FULL:
            begin
                if (inc_b)
                begin
                    st_next.b_low_reg = full_b[7:0];
                    st_next.b_high_reg = full_b[15:8];
                    if (mode_a != TMR_MODE_SPLIT)
                    begin
                        ovf_b = &{st_reg.b_high_reg, st_reg.b_low_reg};
                    end
                end
            end
            TMR_MODE_RELOAD:
            begin
                if (inc_b)
                begin
                    st_next.b_low_reg = low_b[8] ? st_reg.b_high_reg
                                                 : low_b[7:0];
                    if (mode_a != TMR_MODE_SPLIT)
                    begin
                        ovf_b = low_b[8];
                    end
                end
            end
            TMR_MODE_SPLIT:
            begin
                st_next.b_low_reg = st_reg.b_low_reg;
            end
        endcase

        // --------------------------------------------------------------
        // software writes win over the increment just computed
        // --------------------------------------------------------------
        ctrl = st_reg.ctrl_reg;
        if (any_wr)
        begin
            unique case (sfr_addr)
                `TMR_ADDR_CTRL: ctrl = wr_byte;
                `TMR_ADDR_MODE: st_next.mode_reg = wr_byte;
                `TMR_ADDR_A_LOW: st_next.a_low_reg = wr_byte;
                `TMR_ADDR_B_LOW: st_next.b_low_reg = wr_byte;
                `TMR_ADDR_A_HIGH: st_next.a_high_reg = wr_byte;
                `TMR_ADDR_B_HIGH: st_next.b_high_reg = wr_byte;
                default:
                begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // flags: vector clears, then hardware sets win
        // --------------------------------------------------------------
        if (vector_ack_ovf_a)
        begin
            ctrl[`TMR_CTRL_A_OVF] = 1'b0;
        end
        if (vector_ack_ovf_b)
        begin
            ctrl[`TMR_CTRL_B_OVF] = 1'b0;
        end
        if (vector_ack_irq_a & st_reg.ctrl_reg[`TMR_CTRL_A_TYPE])
        begin
            ctrl[`TMR_CTRL_A_IRQ] = 1'b0;
        end
        if (vector_ack_irq_b & st_reg.ctrl_reg[`TMR_CTRL_B_TYPE])
        begin
            ctrl[`TMR_CTRL_B_IRQ] = 1'b0;
        end
        ctrl[`TMR_CTRL_A_OVF] = ctrl[`TMR_CTRL_A_OVF] | ovf_a;
        ctrl[`TMR_CTRL_B_OVF] = ctrl[`TMR_CTRL_B_OVF] | ovf_b;
        // type one: falling edge latches; type zero: flag is the low level
        if (st_reg.ctrl_reg[`TMR_CTRL_A_TYPE])
        begin
            ctrl[`TMR_CTRL_A_IRQ] = ctrl[`TMR_CTRL_A_IRQ] | pin_fall[0];
        end
        else
        begin
            ctrl[`TMR_CTRL_A_IRQ] = ~pin_lvl[0];
        end
        if (st_reg.ctrl_reg[`TMR_CTRL_B_TYPE])
        begin
            ctrl[`TMR_CTRL_B_IRQ] = ctrl[`TMR_CTRL_B_IRQ] | pin_fall[1];
        end
        else
        begin
            ctrl[`TMR_CTRL_B_IRQ] = ~pin_lvl[1];
        end
        st_next.ctrl_reg = ctrl;

        // --------------------------------------------------------------
        // read return, registered; refused accesses read ones
        // --------------------------------------------------------------
        if (sfr_rd)
        begin
            st_next.rdata_reg = acc_ok ? cur_byte : `TMR_UNIMPL_READ;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '{ctrl_reg: `TMR_RST_CTRL,
                        mode_reg: `TMR_RST_MODE,
                        a_low_reg: `TMR_RST_COUNT,
                        a_high_reg: `TMR_RST_COUNT,
                        b_low_reg: `TMR_RST_COUNT,
                        b_high_reg: `TMR_RST_COUNT,
                        rdata_reg: `TMR_RST_RDATA};
        end
        else if (run_en)
        begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata = st_reg.rdata_reg;
    assign counter_a_overflow_flag = st_reg.ctrl_reg[`TMR_CTRL_A_OVF];
    assign counter_b_overflow_flag = st_reg.ctrl_reg[`TMR_CTRL_B_OVF];
    assign ext_irq_a_request = st_reg.ctrl_reg[`TMR_CTRL_A_IRQ];
    assign ext_irq_b_request = st_reg.ctrl_reg[`TMR_CTRL_B_IRQ];

endmodule

/* tmr_top_checker.sv */
// assertion checker for the dual timer/counter register port
`timescale 1ns/1ps
module tmr_top_checker
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_indirect,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic power_down_request,
    input wire logic counter_a_overflow_flag,
    input wire logic counter_b_overflow_flag,
    input wire logic ext_irq_a_request,
    input wire logic ext_irq_b_request
);
    // --------
    // properties
    // --------
    wire live = ce && !power_down_request;
    wire dir = live && !sfr_indirect;
    wire ctl = sfr_addr == 8'h88;
    wire [3:0] fl = {counter_b_overflow_flag, counter_a_overflow_flag,
        ext_irq_b_request, ext_irq_a_request};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    a_indirect_read: assert property (sfr_rd && live &&
        (sfr_indirect || !sfr_addr[7]) |=> sfr_rdata == 8'hFF)
        else $error("indirect read not all ones");
    a_unmapped_read: assert property (sfr_rd && dir && sfr_addr[7] &&
        (sfr_addr < 8'h88 || sfr_addr > 8'h8D) |=> sfr_rdata == 8'hFF)
        else $error("unmapped read not all ones");
    a_ctrl_readback: assert property (sfr_rd && dir && ctl |=>
        {sfr_rdata[7], sfr_rdata[5], sfr_rdata[3], sfr_rdata[1]} == $past(fl))
        else $error("control read differs from flags");
    a_bit_set_flag: assert property (sfr_bit_wr && dir && ctl &&
        sfr_bit_sel == 3'h5 && sfr_bit_val |=> counter_a_overflow_flag)
        else $error("bit write did not set flag");
    a_byte_set_flag: assert property (sfr_wr && !sfr_bit_wr && dir &&
        ctl && sfr_wdata[7] |=> counter_b_overflow_flag)
        else $error("byte write did not set flag");
    a_pd_flags_freeze: assert property (power_down_request |=>
        $stable(fl))
        else $error("flags moved in power down");
    a_pd_read_lost: assert property (sfr_rd && power_down_request |=>
        $stable(sfr_rdata))
        else $error("read served in power down");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without read");
    c_ovf_a: cover property ($rose(counter_a_overflow_flag));
    c_ovf_b: cover property ($rose(counter_b_overflow_flag));
    c_irq_a: cover property ($rose(ext_irq_a_request));
endmodule

bind tmr_top tmr_top_checker chk
(
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_indirect(sfr_indirect), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
    .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .power_down_request(power_down_request),
    .counter_a_overflow_flag(counter_a_overflow_flag),
    .counter_b_overflow_flag(counter_b_overflow_flag),
    .ext_irq_a_request(ext_irq_a_request),
    .ext_irq_b_request(ext_irq_b_request)
);

/* tmr_core_model.sv */
// core model: answers enabled flags with one-cycle vector pulses
`timescale 1ns/1ps
module tmr_core_model
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] vec_en,
    input wire logic [3:0] flags,
    output logic [3:0] vec_ack
);
    // one pulse where the vector clears the flag; a level-type irq flag draws a pulse every other cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            vec_ack <= 4'h0;
        else
            vec_ack <= vec_en & flags & ~vec_ack;
    end
endmodule

/* tmr_top_bench.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module tmr_top_bench;
    logic clk_sys = 0, rstn = 0, sfr_indirect = 0, sfr_wr = 0, sfr_rd = 0;
    logic sfr_bit_wr = 0, sfr_bit_val = 0, cs_a = 0, cs_b = 0, sleep = 0;
    logic pwr_dn = 0, irq_a = 1, irq_b = 1, cnt_b = 1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [3:0] vec_en = 4'h0;
    wire [7:0] sfr_rdata;
    wire [3:0] fl, ack;
    int miscompares = 0, checks_done = 0;
    tmr_top dut
    (
        .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .sfr_addr(sfr_addr),
        .sfr_indirect(sfr_indirect), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .vector_ack_ovf_a(ack[2]),
        .vector_ack_ovf_b(ack[3]), .vector_ack_irq_a(ack[0]),
        .vector_ack_irq_b(ack[1]), .counter_a_clock_select(cs_a),
        .counter_b_clock_select(cs_b), .cpu_sleep_request(sleep),
        .power_down_request(pwr_dn), .ext_irq_a_pin(irq_a),
        .ext_irq_b_pin(irq_b), .count_a_pin(1'b1), .count_b_pin(cnt_b),
        .counter_a_overflow_flag(fl[2]), .counter_b_overflow_flag(fl[3]),
        .ext_irq_a_request(fl[0]), .ext_irq_b_request(fl[1])
    );
    tmr_core_model core
    (
        .clk_sys(clk_sys), .rstn(rstn), .vec_en(vec_en), .flags(fl),
        .vec_ack(ack)
    );
    // --------
    // bus tasks
    // --------
    initial
        forever #20 clk_sys = ~clk_sys;
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task automatic bw(logic [2:0] s, logic v, logic [7:0] a = 8'h88);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_bit_sel <= s;
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_bit_wr <= 1'b0;
    endtask
    task automatic fail(string n, logic [7:0] lo, hi, got);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, got);
        end
    endtask
    task automatic rc(string n, logic [7:0] a, logic [7:0] lo, hi);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        fail(n, lo, hi, sfr_rdata);
    endtask
    // bounded wait, sampled mid-cycle where flags are settled
    task automatic wf(string n, int i, logic v);
        for (int k = 0; k < 300 && fl[i] !== v; k++)
            @(negedge clk_sys);
        fail(n, {7'h00, v}, {7'h00, v}, {7'h00, fl[i]});
    endtask
    task automatic r48(string n, logic c, s, p, logic [7:0] lo, hi);
        wr(8'h8A, 8'h00);
        cs_a <= c;
        sleep <= s;
        bw(3'h4, 1'b1);
        pwr_dn <= p;
        repeat (48) @(posedge clk_sys);
        pwr_dn <= 1'b0;
        bw(3'h4, 1'b0);
        rc(n, 8'h8A, lo, hi);
        $display("test %s done", n);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
    // --------
    // tests
    // --------
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 8'h88; i <= 8'h8D; i++)
            rc("reset", i[7:0], 8'h00, 8'h00);
        wr(8'h8E, 8'h00);
        rc("unmapped", 8'h8E, 8'hFF, 8'hFF);
        rc("low space", 8'h10, 8'hFF, 8'hFF);
        @(posedge clk_sys) sfr_indirect <= 1'b1;
        wr(8'h89, 8'h55);
        rc("indirect", 8'h88, 8'hFF, 8'hFF);
        @(posedge clk_sys) sfr_indirect <= 1'b0;
        bw(3'h0, 1'b1, 8'h89);
        rc("mode", 8'h89, 8'h00, 8'h00);
        bw(3'h5, 1'b1);
        wr(8'h88, 8'h80);
        rc("ctrl", 8'h88, 8'h80, 8'h80);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h01);
        r48("fast", 1, 0, 0, 8'h0B, 8'h0D);
        r48("slow", 0, 0, 0, 8'h03, 8'h05);
        r48("sleep", 1, 1, 0, 8'h0B, 8'h0D);
        r48("power down", 1, 0, 1, 8'h00, 8'h02);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hFF);
        bw(3'h4, 1'b1);
        wf("ovf full", 2, 1'b1);
        bw(3'h4, 1'b0);
        rc("full high", 8'h8C, 8'h00, 8'h00);
        vec_en <= 4'h4;
        wf("ovf ack", 2, 1'b0);
        vec_en <= 4'h0;
        wr(8'h89, 8'h00);
        wr(8'h8A, 8'h1E);
        wr(8'h8C, 8'hFF);
        bw(3'h4, 1'b1);
        wf("ovf prescale", 2, 1'b1);
        bw(3'h4, 1'b0);
        rc("pre high", 8'h8C, 8'h00, 8'h00);
        rc("pre low", 8'h8A, 8'h00, 8'h02);
        wr(8'h89, 8'h20);
        wr(8'h8D, 8'hF0);
        wr(8'h8B, 8'hFE);
        cs_b <= 1'b1;
        bw(3'h6, 1'b1);
        wf("ovf reload", 3, 1'b1);
        bw(3'h6, 1'b0);
        rc("reload high", 8'h8D, 8'hF0, 8'hF0);
        rc("reload low", 8'h8B, 8'hF0, 8'hF2);
        $display("test modes done");
        wr(8'h89, 8'h50);
        wr(8'h8B, 8'h00);
        bw(3'h6, 1'b1);
        repeat (3)
        begin
            repeat (4) @(posedge clk_sys);
            cnt_b <= 1'b0;
            repeat (4) @(posedge clk_sys);
            cnt_b <= 1'b1;
        end
        repeat (6) @(posedge clk_sys);
        bw(3'h6, 1'b0);
        rc("pin count", 8'h8B, 8'h03, 8'h03);
        wr(8'h89, 8'h39);
        wr(8'h8B, 8'h00);
        wr(8'h8A, 8'h00);
        irq_a <= 1'b0;
        repeat (4) @(posedge clk_sys);
        bw(3'h6, 1'b1);
        bw(3'h4, 1'b1);
        repeat (48) @(posedge clk_sys);
        rc("b hold", 8'h8B, 8'h00, 8'h00);
        rc("gated", 8'h8A, 8'h00, 8'h00);
        wr(8'h88, 8'h00);
        irq_a <= 1'b1;
        repeat (4) @(posedge clk_sys);
        $display("test pins done");
        wr(8'h88, 8'h01);
        irq_a <= 1'b0;
        repeat (4) @(posedge clk_sys);
        irq_a <= 1'b1;
        wf("edge irq", 0, 1'b1);
        vec_en <= 4'h1;
        wf("edge ack", 0, 1'b0);
        vec_en <= 4'h0;
        @(posedge clk_sys) irq_b <= 1'b0;
        wf("level irq", 1, 1'b1);
        @(posedge clk_sys) irq_b <= 1'b1;
        wf("level drop", 1, 1'b0);
        wr(8'h89, 8'h03);
        wr(8'h8C, 8'hFF);
        bw(3'h6, 1'b1);
        wf("split b", 3, 1'b1);
        $display("test irq done");
        finish_test();
    end
endmodule
